// [rtl/lsu_pkg.sv]
// constants and types for the logic, shift, conditional-move and byte-compare unit
package lsu_pkg;
	localparam int DATA_W = 64;
	localparam int LIT_W = 8;
	localparam int SHAMT_W = 6;
	localparam int BYTES = 8;
	localparam int REG_IDX_W = 5;
	localparam logic [4:0] ZERO_REG_IDX = 5'h1F;
	localparam logic [63:0] RESULT_RST = 64'h0;
	typedef enum logic [4:0] {
		OP_AND,
		OP_INCLUSIVE_DISJUNCTION,
		OP_XOR,
		OP_CONJ_WITH_COMPLEMENT,
		OP_DISJ_WITH_INVERSE,
		OP_EQUIVALENCE_OP,
		OP_MOVE_IF_ZERO,
		OP_MOVE_IF_NONZERO,
		OP_MOVE_IF_NEGATIVE,
		OP_MOVE_IF_NONPOSITIVE,
		OP_MOVE_IF_POSITIVE,
		OP_MOVE_IF_NONNEGATIVE,
		OP_MOVE_IF_LSB_CLEAR,
		OP_MOVE_IF_LSB_SET,
		OP_LOGICAL_LEFT_SHIFT,
		OP_LOGICAL_RIGHT_SHIFT,
		OP_ARITHMETIC_RIGHT_SHIFT,
		OP_BYTEWISE_UNSIGNED_COMPARE
	} func_t;
endpackage : lsu_pkg

// [rtl/byte_compare.sv]
// eight parallel unsigned byte compares producing a low-byte mask
`timescale 1ns/100ps
`default_nettype none
module byte_compare
	import lsu_pkg::*;
(
	input wire logic [63:0] a_val,
	input wire logic [63:0] b_val,
	output logic [63:0] mask
);
	// carry out of a + ~b + 1 per byte is the unsigned a >= b result
	always_comb begin
		mask = 64'h0; // upper 56 bits stay zero
		for (int i = 0; i < BYTES; i++) begin
			logic [8:0] sum;
			sum = 9'h0;
			sum = {1'b0, a_val[i*8 +: 8]} + {1'b0, ~b_val[i*8 +: 8]} + 9'h001;
			mask[i] = sum[8]; // bit i answers byte i
		end
	end
endmodule : byte_compare
`default_nettype wire

// [rtl/logic_shift_cmov_bytecmp_unit.sv]
// integer datapath slice: boolean ops, conditional moves, shifts, byte compare
`timescale 1ns/100ps
`default_nettype none
module logic_shift_cmov_bytecmp_unit
	import lsu_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic issue_valid,
	input wire func_t func,
	input wire logic [4:0] first_source_idx,
	input wire logic [63:0] first_source_val,
	input wire logic [63:0] second_source_val,
	input wire logic [7:0] literal,
	input wire logic use_literal,
	input wire logic [4:0] destination_idx,
	output logic wb_valid_r,
	output logic [4:0] wb_idx_r,
	output logic [63:0] wb_data_r,
	output logic exception_r
);
	logic [63:0] a_val;
	logic [63:0] b_val;
	logic [63:0] bool_b;
	logic [5:0] shamt;
	logic [63:0] cmp_mask;
	logic cond_true;
	logic [63:0] result;
	logic write_en;
	logic wb_valid_nxt;
	logic [4:0] wb_idx_nxt;
	logic [63:0] wb_data_nxt;

	// condition test of the first operand against zero or its low bit
	function automatic logic cond_test(input func_t f, input logic [63:0] v);
		logic zero;
		logic neg;
		zero = (v == 64'h0);
		neg = v[63];
		unique case (f)
			OP_MOVE_IF_ZERO: cond_test = zero;
			OP_MOVE_IF_NONZERO: cond_test = !zero;
			OP_MOVE_IF_NEGATIVE: cond_test = neg;
			OP_MOVE_IF_NONPOSITIVE: cond_test = neg || zero;
			OP_MOVE_IF_POSITIVE: cond_test = !neg && !zero;
			OP_MOVE_IF_NONNEGATIVE: cond_test = !neg;
			OP_MOVE_IF_LSB_CLEAR: cond_test = !v[0];
			OP_MOVE_IF_LSB_SET: cond_test = v[0];
			default: cond_test = 1'b0;
		endcase
	endfunction : cond_test

	// operand selection; the zero register always reads as zero
	always_comb begin
		a_val = (first_source_idx == ZERO_REG_IDX) ? 64'h0 : first_source_val;
		b_val = use_literal ? {56'h0, literal} : second_source_val;
		shamt = b_val[5:0]; // upper count bits ignored
		bool_b = (func == OP_CONJ_WITH_COMPLEMENT || func == OP_DISJ_WITH_INVERSE
			|| func == OP_EQUIVALENCE_OP) ? ~b_val : b_val;
		cond_true = cond_test(func, a_val);
	end

	byte_compare u_byte_compare (
		.a_val(a_val),
		.b_val(b_val),
		.mask(cmp_mask)
	);

	// result mux; a failed move suppresses the write so the old value stays
	always_comb begin
		result = 64'h0;
		write_en = 1'b1;
		unique case (func)
			OP_AND, OP_CONJ_WITH_COMPLEMENT: result = a_val & bool_b;
			OP_INCLUSIVE_DISJUNCTION, OP_DISJ_WITH_INVERSE: result = a_val | bool_b;
			OP_XOR, OP_EQUIVALENCE_OP: result = a_val ^ bool_b;
			OP_MOVE_IF_ZERO, OP_MOVE_IF_NONZERO, OP_MOVE_IF_NEGATIVE, OP_MOVE_IF_NONPOSITIVE,
			OP_MOVE_IF_POSITIVE, OP_MOVE_IF_NONNEGATIVE, OP_MOVE_IF_LSB_CLEAR,
			OP_MOVE_IF_LSB_SET: begin
				result = b_val;
				write_en = cond_true;
			end
			OP_LOGICAL_LEFT_SHIFT: result = a_val << shamt;
			OP_LOGICAL_RIGHT_SHIFT: result = a_val >> shamt;
			OP_ARITHMETIC_RIGHT_SHIFT: result = 64'($signed(a_val) >>> shamt);
			OP_BYTEWISE_UNSIGNED_COMPARE: result = cmp_mask;
			default: write_en = 1'b0;
		endcase
	end

	// write-back stage next values
	always_comb begin
		wb_valid_nxt = issue_valid && write_en;
		wb_idx_nxt = destination_idx;
		wb_data_nxt = result;
	end

	// write-back stage registers; exception flag is never raised
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_valid_r <= 1'b0;
			wb_idx_r <= 5'h00;
			wb_data_r <= RESULT_RST;
			exception_r <= 1'b0;
		end else begin
			wb_valid_r <= wb_valid_nxt;
			wb_idx_r <= wb_idx_nxt;
			wb_data_r <= wb_data_nxt;
			exception_r <= 1'b0;
		end
	end

	// checks, all on the core clock and quiet while reset is held
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// reference byte compare for the checks, built from plain relational compares
	// rather than the carry trick, so a slip in either one shows as a mismatch
	function automatic logic [7:0] ge_mask(input logic [63:0] x, input logic [63:0] y);
		ge_mask = 8'h00;
		for (int i = 0; i < BYTES; i++) begin
			ge_mask[i] = (x[i*8 +: 8] >= y[i*8 +: 8]);
		end
	endfunction : ge_mask

	// boolean results land one cycle after issue; three forms take the inverse of b
	bool_and_a: assert property (
		issue_valid && func == OP_AND
		|=> wb_data_r == ($past(a_val) & $past(b_val)))
		else $error("and result wrong");
	bool_or_a: assert property (
		issue_valid && func == OP_INCLUSIVE_DISJUNCTION
		|=> wb_data_r == ($past(a_val) | $past(b_val)))
		else $error("or result wrong");
	bool_xor_a: assert property (
		issue_valid && func == OP_XOR
		|=> wb_data_r == ($past(a_val) ^ $past(b_val)))
		else $error("xor result wrong");
	bool_compl_a: assert property (
		issue_valid && func == OP_CONJ_WITH_COMPLEMENT
		|=> wb_data_r == ($past(a_val) & ~$past(b_val)))
		else $error("and-with-complement result wrong");
	bool_disj_with_inverse_a: assert property (
		issue_valid && func == OP_DISJ_WITH_INVERSE
		|=> wb_data_r == ($past(a_val) | ~$past(b_val)))
		else $error("or-with-inverse result wrong");
	bool_eqv_a: assert property (
		issue_valid && func == OP_EQUIVALENCE_OP
		|=> wb_data_r == ($past(a_val) ^ ~$past(b_val)))
		else $error("equivalence result wrong");
	// the zero register as first source turns or-with-inverse into a plain not
	not_via_zero_a: assert property (
		issue_valid && func == OP_DISJ_WITH_INVERSE && first_source_idx == ZERO_REG_IDX
		|=> wb_data_r == ~$past(b_val))
		else $error("complement via zero register wrong");

	// second operand source: register when the literal is off, zero-extended byte otherwise
	reg_pick_a: assert property (
		issue_valid && !use_literal && func == OP_XOR
		|=> wb_data_r == ($past(a_val) ^ $past(second_source_val)))
		else $error("register operand not used");
	lit_pick_a: assert property (
		issue_valid && use_literal && func == OP_XOR
		|=> wb_data_r == ($past(a_val) ^ {56'h0, $past(literal)}))
		else $error("literal operand not used");
	lit_extend_a: assert property (
		issue_valid && use_literal && func == OP_INCLUSIVE_DISJUNCTION && first_source_idx == ZERO_REG_IDX
		|=> wb_data_r[63:8] == 56'h0)
		else $error("literal not zero-extended");

	// write-back control: index follows, idle cycles never write, illegal codes never write
	wb_idx_a: assert property (
		issue_valid
		|=> wb_idx_r == $past(destination_idx))
		else $error("destination index lost");
	idle_quiet_a: assert property (
		!issue_valid
		|=> !wb_valid_r)
		else $error("write without issue");
	always_write_a: assert property (
		issue_valid && func inside {OP_AND, OP_INCLUSIVE_DISJUNCTION, OP_XOR, OP_CONJ_WITH_COMPLEMENT,
		OP_DISJ_WITH_INVERSE, OP_EQUIVALENCE_OP, OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
		OP_ARITHMETIC_RIGHT_SHIFT, OP_BYTEWISE_UNSIGNED_COMPARE}
		|=> wb_valid_r)
		else $error("unconditional result not written");
	bad_func_a: assert property (
		issue_valid && func > OP_BYTEWISE_UNSIGNED_COMPARE
		|=> !wb_valid_r)
		else $error("illegal code wrote destination");
	// the flag is tied low, so this only guards against a later edit wiring it up
	no_exc_a: assert property (exception_r == 1'b0)
		else $error("exception raised");

	// conditional moves: the write strobe tracks the condition on the first operand,
	// and a taken move always carries the second operand unchanged
	cmov_hold_a: assert property (
		issue_valid && func == OP_MOVE_IF_ZERO && a_val != 64'h0
		|=> !wb_valid_r)
		else $error("failed move wrote destination");
	cmov_write_a: assert property (
		issue_valid && func == OP_MOVE_IF_NEGATIVE && a_val[63]
		|=> wb_valid_r && wb_data_r == $past(b_val))
		else $error("taken move lost");
	cmov_eq_a: assert property (
		issue_valid && func == OP_MOVE_IF_ZERO
		|=> wb_valid_r == ($past(a_val) == 64'h0))
		else $error("move if zero condition wrong");
	cmov_ne_a: assert property (
		issue_valid && func == OP_MOVE_IF_NONZERO
		|=> wb_valid_r == ($past(a_val) != 64'h0))
		else $error("move if nonzero condition wrong");
	cmov_lt_a: assert property (
		issue_valid && func == OP_MOVE_IF_NEGATIVE
		|=> wb_valid_r == $past(a_val[63]))
		else $error("move if negative condition wrong");
	cmov_le_a: assert property (
		issue_valid && func == OP_MOVE_IF_NONPOSITIVE
		|=> wb_valid_r == ($past(a_val[63]) || $past(a_val) == 64'h0))
		else $error("move if nonpositive condition wrong");
	cmov_gt_a: assert property (
		issue_valid && func == OP_MOVE_IF_POSITIVE
		|=> wb_valid_r == (!$past(a_val[63]) && $past(a_val) != 64'h0))
		else $error("move if positive condition wrong");
	cmov_ge_a: assert property (
		issue_valid && func == OP_MOVE_IF_NONNEGATIVE
		|=> wb_valid_r == !$past(a_val[63]))
		else $error("move if nonnegative condition wrong");
	cmov_lbc_a: assert property (
		issue_valid && func == OP_MOVE_IF_LSB_CLEAR
		|=> wb_valid_r == !$past(a_val[0]))
		else $error("move if low bit clear condition wrong");
	cmov_lbs_a: assert property (
		issue_valid && func == OP_MOVE_IF_LSB_SET
		|=> wb_valid_r == $past(a_val[0]))
		else $error("move if low bit set condition wrong");
	cmov_data_a: assert property (
		issue_valid && func inside {OP_MOVE_IF_ZERO, OP_MOVE_IF_NONZERO, OP_MOVE_IF_NEGATIVE,
		OP_MOVE_IF_NONPOSITIVE, OP_MOVE_IF_POSITIVE, OP_MOVE_IF_NONNEGATIVE,
		OP_MOVE_IF_LSB_CLEAR, OP_MOVE_IF_LSB_SET}
		|=> !wb_valid_r || wb_data_r == $past(b_val))
		else $error("taken move carried wrong value");

	// shifts: count is the low six bits, logical fills zero, arithmetic fills the sign
	shift_left_a: assert property (
		issue_valid && func == OP_LOGICAL_LEFT_SHIFT && b_val[5:0] == 6'h3F
		|=> wb_data_r == {$past(a_val[0]), 63'h0})
		else $error("left shift by 63 wrong");
	sra_sign_a: assert property (
		issue_valid && func == OP_ARITHMETIC_RIGHT_SHIFT && b_val[5:0] == 6'h3F
		|=> wb_data_r == {64{$past(a_val[63])}})
		else $error("arithmetic shift sign fill wrong");
	srl_fill_a: assert property (
		issue_valid && func == OP_LOGICAL_RIGHT_SHIFT && b_val[5:0] == 6'h08
		|=> wb_data_r[63:56] == 8'h00)
		else $error("logical right shift fill wrong");
	sll_a: assert property (
		issue_valid && func == OP_LOGICAL_LEFT_SHIFT
		|=> wb_data_r == ($past(a_val) << $past(b_val[5:0])))
		else $error("left shift result wrong");
	srl_a: assert property (
		issue_valid && func == OP_LOGICAL_RIGHT_SHIFT
		|=> wb_data_r == ($past(a_val) >> $past(b_val[5:0])))
		else $error("logical right shift result wrong");
	sra_a: assert property (
		issue_valid && func == OP_ARITHMETIC_RIGHT_SHIFT
		|=> wb_data_r == 64'($signed($past(a_val)) >>> $past(b_val[5:0])))
		else $error("arithmetic right shift result wrong");
	shift_zero_a: assert property (
		issue_valid && b_val[5:0] == 6'h00
		&& func inside {OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT, OP_ARITHMETIC_RIGHT_SHIFT}
		|=> wb_data_r == $past(a_val))
		else $error("shift by zero changed operand");

	// byte compare: one mask bit per byte, everything above the low byte cleared
	cmpb_upper_a: assert property (
		issue_valid && func == OP_BYTEWISE_UNSIGNED_COMPARE
		|=> wb_data_r[63:8] == 56'h0 && wb_data_r[0] == ($past(a_val[7:0]) >= $past(b_val[7:0])))
		else $error("byte compare layout wrong");
	cmpb_mask_a: assert property (
		issue_valid && func == OP_BYTEWISE_UNSIGNED_COMPARE
		|=> wb_data_r == {56'h0, ge_mask($past(a_val), $past(b_val))})
		else $error("byte compare mask wrong");

	// main scenarios that the bench should reach
	cmov_taken_c: cover property (issue_valid && func == OP_MOVE_IF_LSB_SET && a_val[0]);
	sra_neg_c: cover property (issue_valid && func == OP_ARITHMETIC_RIGHT_SHIFT && a_val[63]);
	cmpb_mix_c: cover property (issue_valid && func == OP_BYTEWISE_UNSIGNED_COMPARE
		&& cmp_mask[7:0] != 8'h00 && cmp_mask[7:0] != 8'hFF);
	eqv_lit_c: cover property (issue_valid && func == OP_EQUIVALENCE_OP && use_literal);
	bad_func_c: cover property (issue_valid && func > OP_BYTEWISE_UNSIGNED_COMPARE);
endmodule : logic_shift_cmov_bytecmp_unit
`default_nettype wire

// [bench/regfile_model.sv]
// register file model: feeds the first operand, takes the write-back
`timescale 1ns/100ps
`default_nettype none
module regfile_model
	import lsu_pkg::*;
(
	input wire logic core_clk,
	input wire logic [4:0] rd_idx,
	output logic [63:0] rd_val,
	input wire logic wr_en,
	input wire logic [4:0] wr_idx,
	input wire logic [63:0] wr_data,
	input wire logic [4:0] peek_idx,
	output logic [63:0] peek_val
);
	logic [63:0] mem_r [32];
	// zero register always reads zero
	assign rd_val = (rd_idx == ZERO_REG_IDX) ? 64'h0 : mem_r[rd_idx];
	assign peek_val = mem_r[peek_idx];
	// only a committed result changes the destination
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem_r[wr_idx] <= wr_data;
		end
	end
endmodule : regfile_model
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the logic, shift, move and byte-compare unit
`timescale 1ns/100ps
`default_nettype none
module tb import lsu_pkg::*;;
	localparam logic [63:0] VA = 64'h807F_0012_FF01_5634;
	localparam logic [63:0] VB = 64'h7F80_0012_00FF_3456;
	localparam logic [63:0] CV [4] = '{64'h0, 64'h1, 64'hFFFF_FFFF_FFFF_FFFE, 64'h2};
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic issue_valid = 1'b0;
	func_t func = OP_AND;
	logic [4:0] ra_idx = 5'h00;
	logic [63:0] ra_val;
	logic [63:0] b_val = 64'h0;
	logic [7:0] literal = 8'h00;
	logic use_lit = 1'b0;
	logic [4:0] dest = 5'h00;
	logic wb_valid_r;
	logic [4:0] wb_idx_r;
	logic [63:0] wb_data_r;
	logic exception_r;
	logic [63:0] peek_val;
	int fails = 0;
	int n_checks = 0;
	int cycles = 0;
	always #10 core_clk = ~core_clk;
	logic_shift_cmov_bytecmp_unit dut (.core_clk(core_clk), .rst_n(rst_n), .issue_valid(issue_valid),
		.func(func), .first_source_idx(ra_idx), .first_source_val(ra_val), .second_source_val(b_val),
		.literal(literal), .use_literal(use_lit), .destination_idx(dest), .wb_valid_r(wb_valid_r),
		.wb_idx_r(wb_idx_r), .wb_data_r(wb_data_r), .exception_r(exception_r));
	regfile_model rf (.core_clk(core_clk), .rd_idx(ra_idx), .rd_val(ra_val), .wr_en(wb_valid_r),
		.wr_idx(wb_idx_r), .wr_data(wb_data_r), .peek_idx(5'h05), .peek_val(peek_val));
	task automatic end_of_test();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// register operand gets the inverse when the literal is chosen, so a wrong pick shows
	task automatic op(input func_t f, input logic [4:0] a, input logic [63:0] b, input logic ul,
		input logic [4:0] d, input logic ev, input logic [63:0] ed);
		@(posedge core_clk);
		issue_valid <= 1'b1;
		func <= f;
		ra_idx <= a;
		b_val <= ul ? ~b : b;
		literal <= b[7:0];
		use_lit <= ul;
		dest <= d;
		@(posedge core_clk);
		issue_valid <= 1'b0;
		#1;
		chk(64'(wb_valid_r), 64'(ev));
		chk(64'(exception_r), 64'h0);
		if (ev) begin
			chk(wb_data_r, ed);
			chk(64'(wb_idx_r), 64'(d));
		end
	endtask : op
	task automatic mv(input logic [4:0] d, input logic [63:0] v);
		op(OP_MOVE_IF_ZERO, 5'h1F, v, 1'b0, d, 1'b1, v);
	endtask : mv
	task automatic t_logic();
		mv(5'h01, VA);
		op(OP_AND, 5'h01, VB, 1'b0, 5'h02, 1'b1, VA & VB);
		op(OP_INCLUSIVE_DISJUNCTION, 5'h01, VB, 1'b0, 5'h02, 1'b1, VA | VB);
		op(OP_XOR, 5'h01, VB, 1'b0, 5'h02, 1'b1, VA ^ VB);
		op(OP_CONJ_WITH_COMPLEMENT, 5'h01, VB, 1'b0, 5'h02, 1'b1, VA & ~VB);
		op(OP_DISJ_WITH_INVERSE, 5'h01, VB, 1'b0, 5'h02, 1'b1, VA | ~VB);
		op(OP_EQUIVALENCE_OP, 5'h01, VB, 1'b0, 5'h02, 1'b1, VA ^ ~VB);
		op(OP_DISJ_WITH_INVERSE, 5'h1F, VB, 1'b0, 5'h03, 1'b1, ~VB);
		op(OP_XOR, 5'h01, 64'hA5, 1'b1, 5'h03, 1'b1, VA ^ 64'hA5);
		op(OP_INCLUSIVE_DISJUNCTION, 5'h1F, 64'hA5, 1'b1, 5'h03, 1'b1, 64'hA5);
		op(OP_EQUIVALENCE_OP, 5'h01, 64'h5A, 1'b1, 5'h03, 1'b1, VA ^ ~64'h5A);
		// an unused function code must leave the destination alone
		op(func_t'(5'h1F), 5'h01, VB, 1'b0, 5'h03, 1'b0, VB);
	endtask : t_logic
	task automatic t_cmov();
		logic [63:0] v;
		logic c;
		func_t f;
		for (int k = 0; k < 4; k++) begin
			v = CV[k];
			mv(5'h04, v);
			for (int j = 6; j < 14; j++) begin
				f = func_t'(j);
				case (f)
					OP_MOVE_IF_ZERO: c = v == 64'h0;
					OP_MOVE_IF_NONZERO: c = v != 64'h0;
					OP_MOVE_IF_NEGATIVE: c = v[63];
					OP_MOVE_IF_NONPOSITIVE: c = v[63] || v == 64'h0;
					OP_MOVE_IF_POSITIVE: c = !v[63] && v != 64'h0;
					OP_MOVE_IF_NONNEGATIVE: c = !v[63];
					OP_MOVE_IF_LSB_CLEAR: c = !v[0];
					default: c = v[0];
				endcase
				op(f, 5'h04, VB, 1'b0, 5'h05, c, VB);
			end
		end
		mv(5'h05, 64'h55);
		op(OP_MOVE_IF_NONZERO, 5'h1F, VB, 1'b0, 5'h05, 1'b0, VB);
		@(posedge core_clk);
		#1;
		chk(peek_val, 64'h55);
	endtask : t_cmov
	task automatic t_shift();
		logic [63:0] sb;
		mv(5'h06, VA);
		// counts 0, 21, 42, 63 with junk above the six count bits
		for (int s = 0; s < 64; s += 21) begin
			sb = 64'hFFFF_FFFF_FFFF_FFC0 | 64'(s);
			op(OP_LOGICAL_LEFT_SHIFT, 5'h06, sb, 1'b0, 5'h07, 1'b1, VA << s);
			op(OP_LOGICAL_RIGHT_SHIFT, 5'h06, sb, 1'b0, 5'h07, 1'b1, VA >> s);
			op(OP_ARITHMETIC_RIGHT_SHIFT, 5'h06, sb, 1'b0, 5'h07, 1'b1, 64'($signed(VA) >>> s));
		end
		op(OP_LOGICAL_LEFT_SHIFT, 5'h06, 64'hC4, 1'b1, 5'h07, 1'b1, VA << 4);
		op(OP_LOGICAL_RIGHT_SHIFT, 5'h06, 64'h08, 1'b1, 5'h07, 1'b1, VA >> 8);
	endtask : t_shift
	// mask expected: bit i set when byte i of x is unsigned not below byte i of y
	task automatic t_bcmp();
		mv(5'h08, VA);
		op(OP_BYTEWISE_UNSIGNED_COMPARE, 5'h08, VB, 1'b0, 5'h09, 1'b1, 64'hBA);
		op(OP_BYTEWISE_UNSIGNED_COMPARE, 5'h1F, VB, 1'b0, 5'h09, 1'b1, 64'h28);
	endtask : t_bcmp
	// reset in mid-run clears the write-back stage at once; the unit works again after it
	task automatic t_reset();
		@(posedge core_clk);
		issue_valid <= 1'b1;
		func <= OP_DISJ_WITH_INVERSE;
		ra_idx <= 5'h1F;
		use_lit <= 1'b0;
		dest <= 5'h0A;
		@(posedge core_clk);
		issue_valid <= 1'b0;
		rst_n <= 1'b0;
		#1;
		chk(64'(wb_valid_r), 64'h0);
		chk(64'(wb_idx_r), 64'h0);
		chk(wb_data_r, RESULT_RST);
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		op(OP_AND, 5'h01, VB, 1'b0, 5'h02, 1'b1, VA & VB);
	endtask : t_reset
	// hang guard well above the roughly 150 cycles needed
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			end_of_test();
		end
	end
	initial begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		t_logic();
		t_cmov();
		t_shift();
		t_bcmp();
		t_reset();
		end_of_test();
	end
endmodule : tb
`default_nettype wire
